// >>> core/pic_regs.vh
// register map, field positions and reset values of the pin interface cell
`ifndef PIC_REGS_VH
`define PIC_REGS_VH

`define PIC_ADDR_CFG        8'h00
`define PIC_ADDR_CLKPOL     8'h04
`define PIC_ADDR_STATUS     8'h08

`define PIC_CFG_LATCH       0
`define PIC_CFG_IN_CLK      1
`define PIC_CFG_LE_INV      2
`define PIC_CFG_OUT_REG     3
`define PIC_CFG_OUT_CLK     4
`define PIC_CFG_OUT_INV     5
`define PIC_CFG_OE_INV      6
`define PIC_CFG_PULL_OFF    7
`define PIC_CFG_TRI_LO      8
`define PIC_CFG_TRI_HI      9
`define PIC_CFG_W           10
`define PIC_CFG_RESET       10'h000

`define PIC_TRI_ON          2'h0
`define PIC_TRI_OFF         2'h1
`define PIC_TRI_PIN         2'h2

`define PIC_CLKPOL_W        2
`define PIC_CLKPOL_RESET    2'h0

`define PIC_ST_PIN          0
`define PIC_ST_STORED       1
`define PIC_ST_OUTQ         2
`define PIC_ST_PULL         3
`define PIC_ST_OE           4
`define PIC_ST_CLEAR        5
`define PIC_ST_W            6

`endif

// >>> core/pic_cell.v
// configurable pin interface cell with apb configuration
//
// How it works
// - input storage element selectable as flip-flop or latch, fed from pin input
// - two clock lines per edge, polarity set per line not per element
// - rising-edge line makes latches transparent low; falling-edge makes them transparent high
// - extra inversion in latch-enable path reconciles flip-flop and latch polarity
// - input storage element and output register cleared during configuration and while chip reset is low
// - direct pin input and stored input offered together on separate taps
// - output buffer sourced from direct output or from output register
// - per-cell output inversion option beside the selectable pull-up
// - outside reset, pull-up only allowed while the cell is not used as an output
// - selected pull-up holds an undriven pin steady high
// - high tri-state control disables buffer, low enables, sense invertible
// - output register is rising-edge, clocked by one of two invertible lines
// - pull-up engaged during reset, off one pclk later, since the reset tri code uses the cell as an output
`timescale 1ns/1ps
`include "pic_regs.vh"

module pic_cell (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        chip_reset_n,
  input  wire        config_busy,
  input  wire        clk_line0,
  input  wire        clk_line1,
  input  wire        pin_in,
  input  wire        user_out,
  input  wire        user_tri,
  output reg         pin_out,
  output reg         pin_oe,
  output reg         pin_pullup,
  output reg         direct_in,
  output reg         stored_in
);

  reg  [`PIC_CFG_W-1:0]    cfg;
  reg  [`PIC_CLKPOL_W-1:0] clk_pol;
  reg  [1:0]               line_prev;
  reg                      out_q;
  wire [1:0]               line_raw;
  wire [1:0]               line_eff;
  wire [1:0]               line_rise;
  wire                     clear_all;
  wire                     in_sel;
  wire                     out_sel;
  wire                     in_edge;
  wire                     out_edge;
  wire                     latch_open;
  wire                     cfg_latch;
  wire                     cfg_le_inv;
  wire                     cfg_out_reg;
  wire                     cfg_out_inv;
  wire                     cfg_oe_inv;
  wire                     cfg_pull_off;
  wire [1:0]               tri_mode;
  reg                      tri_ctl;
  reg                      used_as_out;
  reg                      out_src;
  reg                      next_oe;
  reg                      next_out;
  reg                      next_pull;
  reg                      next_stored;
  wire                     setup;
  wire                     wr_access;
  wire                     sel_cfg;
  wire                     sel_clkpol;
  wire                     sel_status;
  wire                     mapped;
  reg  [31:0]              next_rdata;

  assign line_raw = {clk_line1, clk_line0};

  // one polarity bit per line, shared by every element on it
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : gen_line
      assign line_eff[g]  = line_raw[g] ^ clk_pol[g];
      assign line_rise[g] = line_eff[g] & ~line_prev[g];
    end
  endgenerate

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_prev <= 2'h0;
    end else begin
      line_prev <= line_eff;
    end
  end

  assign clear_all    = ~chip_reset_n | config_busy;
  assign cfg_latch    = cfg[`PIC_CFG_LATCH];
  assign in_sel       = cfg[`PIC_CFG_IN_CLK];
  assign cfg_le_inv   = cfg[`PIC_CFG_LE_INV];
  assign cfg_out_reg  = cfg[`PIC_CFG_OUT_REG];
  assign out_sel      = cfg[`PIC_CFG_OUT_CLK];
  assign cfg_out_inv  = cfg[`PIC_CFG_OUT_INV];
  assign cfg_oe_inv   = cfg[`PIC_CFG_OE_INV];
  assign cfg_pull_off = cfg[`PIC_CFG_PULL_OFF];
  assign tri_mode     = {cfg[`PIC_CFG_TRI_HI], cfg[`PIC_CFG_TRI_LO]};
  assign in_edge      = line_rise[in_sel];
  assign out_edge     = line_rise[out_sel];
  // latch opens while its line is low, unless the enable is inverted
  assign latch_open   = ~line_eff[in_sel] ^ cfg_le_inv;

  // latch emulated on pclk: follows while open, holds otherwise
  always @* begin
    next_stored = stored_in;
    if (cfg_latch) begin
      if (latch_open) begin
        next_stored = pin_in;
      end
    end else begin
      if (in_edge) begin
        next_stored = pin_in;
      end
    end
  end

  // spare tri code behaves like pin mode
  always @* begin
    case (tri_mode)
      `PIC_TRI_ON: begin
        tri_ctl     = 1'b0;
        used_as_out = 1'b1;
      end
      `PIC_TRI_OFF: begin
        tri_ctl     = 1'b1;
        used_as_out = 1'b0;
      end
      `PIC_TRI_PIN: begin
        tri_ctl     = user_tri ^ cfg_oe_inv;
        used_as_out = 1'b1;
      end
      default: begin
        tri_ctl     = user_tri ^ cfg_oe_inv;
        used_as_out = 1'b1;
      end
    endcase
    next_oe = ~tri_ctl;
  end

  // inversion applies after the source choice
  always @* begin
    if (cfg_out_reg) begin
      out_src = out_q;
    end else begin
      out_src = user_out;
    end
    next_out = out_src ^ cfg_out_inv;
  end

  // reset value of the off bit is zero, but the reset tri code enables the output, so next_pull is zero from reset on
  always @* begin
    if (cfg_pull_off | used_as_out) begin
      next_pull = 1'b0;
    end else begin
      next_pull = 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stored_in <= 1'b0;
    end else if (clear_all) begin
      stored_in <= 1'b0;
    end else begin
      stored_in <= next_stored;
    end
  end

  // output register moves only on its own line's active edge or on a clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= 1'b0;
    end else if (clear_all) begin
      out_q <= 1'b0;
    end else if (out_edge) begin
      out_q <= user_out;
    end
  end

  // pin stage; direct tap costs one pclk so every output is a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      direct_in <= 1'b0;
    end else begin
      direct_in <= pin_in;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= 1'b0;
    end else begin
      pin_out <= next_out;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_oe <= 1'b0;
    end else begin
      pin_oe <= next_oe;
    end
  end

  // pull-up is engaged during reset; the reset tri code enables the output, so it drops one pclk later
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_pullup <= 1'b1;
    end else begin
      pin_pullup <= next_pull;
    end
  end

  // apb: decode in setup, answer in the first access cycle
  assign setup     = psel & ~penable;
  assign wr_access = psel & penable & pwrite & pready;
  // three words decoded; anything else answers with an error
  assign sel_cfg    = (paddr == `PIC_ADDR_CFG);
  assign sel_clkpol = (paddr == `PIC_ADDR_CLKPOL);
  assign sel_status = (paddr == `PIC_ADDR_STATUS);
  assign mapped     = sel_cfg | sel_clkpol | sel_status;

  always @* begin
    next_rdata = 32'h00000000;
    case (paddr)
      `PIC_ADDR_CFG: begin
        next_rdata[`PIC_CFG_W-1:0] = cfg;
      end
      `PIC_ADDR_CLKPOL: begin
        next_rdata[`PIC_CLKPOL_W-1:0] = clk_pol;
      end
      `PIC_ADDR_STATUS: begin
        next_rdata[`PIC_ST_PIN]    = direct_in;
        next_rdata[`PIC_ST_STORED] = stored_in;
        next_rdata[`PIC_ST_OUTQ]   = out_q;
        next_rdata[`PIC_ST_PULL]   = pin_pullup;
        next_rdata[`PIC_ST_OE]     = pin_oe;
        next_rdata[`PIC_ST_CLEAR]  = clear_all;
      end
      default: begin
        next_rdata = 32'h00000000;
      end
    endcase
  end

  // one-cycle answer: the bus never sees a wait state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup & ~mapped;
    end
  end

  // data is zero outside a read access, so no stale word lingers on the bus
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else begin
      prdata <= (setup & ~pwrite) ? next_rdata : 32'h00000000;
    end
  end

  // writes ignore the status word and unmapped addresses
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= `PIC_CFG_RESET;
    end else if (wr_access & sel_cfg) begin
      cfg <= pwdata[`PIC_CFG_W-1:0];
    end
  end

  // a polarity change flips the line; switch it while the line idles
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_pol <= `PIC_CLKPOL_RESET;
    end else if (wr_access & sel_clkpol) begin
      clk_pol <= pwdata[`PIC_CLKPOL_W-1:0];
    end
  end

endmodule

// >>> test/pic_cell_properties.sv
// assertion checker for the pin interface cell
`timescale 1ns/1ps
module pic_cell_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic chip_reset_n,
  input wire logic config_busy,
  input wire logic pin_in,
  input wire logic pin_oe,
  input wire logic pin_pullup,
  input wire logic direct_in,
  input wire logic stored_in
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence apb_setup_s; psel && !penable; endsequence
  sequence apb_done_s; pready ##1 !pready; endsequence
  apb_ready_a: assert property (apb_setup_s |=> apb_done_s) else $error("ready missing");
  ready_cause_a: assert property (pready |-> $past(psel && !penable)) else $error("stray ready");
  err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  busy_clear_a: assert property (config_busy |=> !stored_in) else $error("busy clear");
  chip_clear_a: assert property (!chip_reset_n |=> !stored_in) else $error("reset clear");
  direct_tap_a: assert property (presetn |=> direct_in == $past(pin_in)) else $error("direct tap");
  pull_out_a: assert property (pin_oe |-> !pin_pullup) else $error("pull-up on output");
  // a change of the stored tap must come from the pin, unless a clear caused it
  store_src_a: assert property ($changed(stored_in) && $past(chip_reset_n && !config_busy)
    |-> stored_in == $past(pin_in)) else $error("stored value source");
endmodule

bind pic_cell pic_cell_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .chip_reset_n(chip_reset_n), .config_busy(config_busy),
  .pin_in(pin_in), .pin_oe(pin_oe), .pin_pullup(pin_pullup), .direct_in(direct_in), .stored_in(stored_in));

// >>> test/pic_pin_model.sv
// board-side model of the package pin
`timescale 1ns/1ps
module pic_pin_model (
  input  wire logic pclk,
  input  wire logic pin_out,
  input  wire logic pin_oe,
  input  wire logic pin_pullup,
  input  wire logic ext_en,
  input  wire logic ext_val,
  output logic      pin_in
);
  logic flt = 1'b0;
  // a floating pin wanders, so a stale level never passes
  always @(posedge pclk) flt <= ~flt;
  assign pin_in = pin_oe ? pin_out : ext_en ? ext_val : pin_pullup ? 1'b1 : flt;
endmodule

// >>> test/tb_pic_cell.sv
// self-checking bench for the pin interface cell
`timescale 1ns/1ps
module tb_pic_cell;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, v;
  logic        chip_reset_n = 1, config_busy = 0, clk_line0 = 0, clk_line1 = 0;
  logic        user_out = 0, user_tri = 0, ext_en = 0, ext_val = 0;
  logic        pready, pslverr, pin_out, pin_oe, pin_pullup, direct_in, stored_in, pin_in;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, seed = 32'hB703;
  logic [11:0] tri_t [4] = '{12'h802, 12'h801, 12'h903, 12'h400};
  logic [64:0] exp_q [$];
  int          n_fail = 0, checks = 0;
  always #12.5 pclk = ~pclk;
  pic_cell dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .chip_reset_n(chip_reset_n),
    .config_busy(config_busy), .clk_line0(clk_line0), .clk_line1(clk_line1), .pin_in(pin_in),
    .user_out(user_out), .user_tri(user_tri), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
    .direct_in(direct_in), .stored_in(stored_in));
  pic_pin_model pin_u (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
    .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task cmp(input string s, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x) begin
      n_fail++;
      $display("mismatch %s exp %h got %h", s, x, g);
    end
  endtask
  task give_verdict;
    if (n_fail == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // reads note data, mask and error flag; the monitor checks them
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input logic e);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    if (!w) exp_q.push_back({e, m, d});
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (!pready);
    {psel, penable} <= 2'b00;
  endtask
  always @(posedge pclk) if (psel && penable && pready && !pwrite) begin : mon
    logic [64:0] e;
    e = exp_q.pop_front();
    cmp("prdata", e[31:0] & e[63:32], prdata & e[63:32]);
    cmp("pslverr", {31'h0, e[64]}, {31'h0, pslverr});
  end
  initial begin
    #75000;
    n_fail++;
    give_verdict;
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    apb(0, 8'h00, 32'h0, 32'hFFFFFFFF, 0);
    apb(0, 8'h04, 32'h0, 32'hFFFFFFFF, 0);
    apb(0, 8'h08, 32'h10, 32'h18, 0);
    apb(1, 8'h0C, 32'h3FF, 0, 0);
    apb(0, 8'h0C, 32'h0, 32'hFFFFFFFF, 1);
    apb(1, 8'h00, 32'h100, 0, 0);
    repeat (3) @(posedge pclk);
    apb(0, 8'h08, 32'h09, 32'h19, 0);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      v = seed[0];
      apb(1, 8'h04, {31'h0, i[0]}, 0, 0);
      apb(1, 8'h00, {31'h80, i[1]}, 0, 0);
      {clk_line0, ext_en, ext_val} <= {i[0], 1'b1, v};
      repeat (3) @(posedge pclk);
      if (i[1]) cmp("latch_open", {31'h0, v}, {31'h0, stored_in});
      clk_line0 <= ~i[0];
      repeat (3) @(posedge pclk);
      cmp("capture", {31'h0, v}, {31'h0, stored_in});
      ext_val <= ~v;
      repeat (3) @(posedge pclk);
      cmp("hold", {31'h0, v}, {31'h0, stored_in});
    end
    apb(1, 8'h00, 32'h105, 0, 0);
    repeat (3) @(posedge pclk);
    cmp("le_open", {31'h0, ~v}, {31'h0, stored_in});
    clk_line0 <= 1;
    repeat (3) @(posedge pclk);
    ext_val <= v;
    repeat (3) @(posedge pclk);
    cmp("le_hold", {31'h0, ~v}, {31'h0, stored_in});
    {clk_line0, ext_val} <= 2'b01;
    repeat (3) @(posedge pclk);
    config_busy <= 1;
    repeat (2) @(posedge pclk);
    cmp("busy_clear", 32'h0, {31'h0, stored_in});
    {config_busy, chip_reset_n} <= 2'b00;
    repeat (2) @(posedge pclk);
    cmp("chip_clear", 32'h0, {31'h0, stored_in});
    {chip_reset_n, ext_en, user_out} <= {2'b10, seed[3]};
    apb(1, 8'h00, 32'h020, 0, 0);
    repeat (3) @(posedge pclk);
    cmp("invert", {31'h0, ~seed[3]}, {31'h0, pin_out});
    apb(1, 8'h00, 32'h018, 0, 0);
    user_out <= 1;
    repeat (3) @(posedge pclk);
    cmp("reg_hold", 32'h0, {31'h0, pin_out});
    clk_line1 <= 1;
    repeat (3) @(posedge pclk);
    cmp("reg_take", 32'h1, {31'h0, pin_out});
    for (int i = 0; i < 4; i++) begin
      apb(1, 8'h00, {22'h0, tri_t[i][11:2]}, 0, 0);
      user_tri <= tri_t[i][1];
      repeat (3) @(posedge pclk);
      cmp("oe", {31'h0, tri_t[i][0]}, {31'h0, pin_oe});
    end
    give_verdict;
  end
endmodule
